// File: hdl/mcil_pkg.sv
// Constants, code bit positions and states of the machine check logic.
package mcil_pkg;

    // Machine check code is 64 bits, bit 0 being the most significant.
    localparam int CODE_W   = 64;
    localparam int CODE_MSB = 63;

    // Interruption type bits.
    localparam int BIT_SD = 0;
    localparam int BIT_PD = 1;
    localparam int BIT_SR = 2;
    localparam int BIT_TD = 3;
    localparam int BIT_CD = 4;

    // Validity bits.
    localparam int BIT_V_MODE    = 20;
    localparam int BIT_V_MASKKEY = 21;
    localparam int BIT_V_PMCC    = 22;
    localparam int BIT_V_IA      = 23;
    localparam int BIT_V_FADDR   = 24;
    localparam int BIT_V_FPR     = 27;
    localparam int BIT_V_GPR     = 28;
    localparam int BIT_V_CR      = 29;
    localparam int BIT_V_STOR    = 31;
    localparam int BIT_V_CPUT    = 46;
    localparam int BIT_V_CKC     = 47;

    // Fixed logout area locations.
    localparam logic [8:0] LOC_CODE  = 9'h0e8;
    localparam logic [8:0] LOC_FADDR = 9'h0f8;
    localparam logic [3:0] LEN_CODE  = 4'h8;
    localparam logic [3:0] LEN_FADDR = 4'h2;

    // Failing address field and the 2K block boundary mask.
    localparam int          FADDR_W    = 16;
    localparam logic [15:0] BLOCK_MASK = 16'hf800;

    // Register port.
    localparam int         REG_W        = 32;
    localparam logic [7:0] ADDR_CR14    = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_CODE_HI = 8'h08;
    localparam logic [7:0] ADDR_CODE_LO = 8'h0c;
    localparam logic [7:0] ADDR_FADDR   = 8'h10;

    // Control register 14 field positions and reset values.
    localparam int   CR14_CSTOP    = 0;
    localparam int   CR14_RMASK    = 1;
    localparam int   CR14_EMASK    = 2;
    localparam logic CR14_CSTOP_RV = 1'b1;
    localparam logic CR14_RMASK_RV = 1'b0;
    localparam logic CR14_EMASK_RV = 1'b1;

    // Status register field positions.
    localparam int ST_SD_P   = 0;
    localparam int ST_PD_P   = 1;
    localparam int ST_SR_P   = 2;
    localparam int ST_TD_P   = 3;
    localparam int ST_CSTOP  = 4;
    localparam int ST_FSM_LO = 8;

    typedef enum logic [2:0] {
        MCIL_IDLE   = 3'b000,
        MCIL_REQ    = 3'b001,
        MCIL_SCODE  = 3'b010,
        MCIL_SADDR  = 3'b011,
        MCIL_CSTOP  = 3'b100
    } mcil_state_t;

    function automatic int code_pos(input int b);
        return CODE_MSB - b;
    endfunction

endpackage

// File: hdl/mcil_code_if.sv
// Carrier between the sequencer and the machine check code builder.
`timescale 1ns/1ps
`default_nettype none
interface mcil_code_if;
    logic                         sd;
    logic                         pd;
    logic                         sr;
    logic                         td;
    logic [3:0]                   v_psw;
    logic [2:0]                   v_regs;
    logic                         v_stor;
    logic [1:0]                   v_timer;
    logic                         key_fail;
    logic                         mbit_err;
    logic [mcil_pkg::FADDR_W-1:0] addr_raw;
    logic [mcil_pkg::CODE_W-1:0]  code;
    logic [mcil_pkg::FADDR_W-1:0] fail_addr;

    modport builder (
        input  sd, pd, sr, td, v_psw, v_regs, v_stor, v_timer,
        input  key_fail, mbit_err, addr_raw,
        output code, fail_addr
    );
    modport owner (
        output sd, pd, sr, td, v_psw, v_regs, v_stor, v_timer,
        output key_fail, mbit_err, addr_raw,
        input  code, fail_addr
    );
endinterface
`default_nettype wire

// File: hdl/mcil_code_build.sv
// Composes the eight-byte machine check code and the failing address.
`timescale 1ns/1ps
`default_nettype none
module mcil_code_build (
    // Code fields in, code word out
    mcil_code_if.builder ifc
);

    localparam int P_SD  = mcil_pkg::code_pos(mcil_pkg::BIT_SD);
    localparam int P_PD  = mcil_pkg::code_pos(mcil_pkg::BIT_PD);
    localparam int P_SR  = mcil_pkg::code_pos(mcil_pkg::BIT_SR);
    localparam int P_TD  = mcil_pkg::code_pos(mcil_pkg::BIT_TD);
    localparam int P_CD  = mcil_pkg::code_pos(mcil_pkg::BIT_CD);
    localparam int P_VM  = mcil_pkg::code_pos(mcil_pkg::BIT_V_MODE);
    localparam int P_VK  = mcil_pkg::code_pos(mcil_pkg::BIT_V_MASKKEY);
    localparam int P_VP  = mcil_pkg::code_pos(mcil_pkg::BIT_V_PMCC);
    localparam int P_VI  = mcil_pkg::code_pos(mcil_pkg::BIT_V_IA);
    localparam int P_VA  = mcil_pkg::code_pos(mcil_pkg::BIT_V_FADDR);
    localparam int P_VF  = mcil_pkg::code_pos(mcil_pkg::BIT_V_FPR);
    localparam int P_VG  = mcil_pkg::code_pos(mcil_pkg::BIT_V_GPR);
    localparam int P_VC  = mcil_pkg::code_pos(mcil_pkg::BIT_V_CR);
    localparam int P_VS  = mcil_pkg::code_pos(mcil_pkg::BIT_V_STOR);
    localparam int P_VT  = mcil_pkg::code_pos(mcil_pkg::BIT_V_CPUT);
    localparam int P_VQ  = mcil_pkg::code_pos(mcil_pkg::BIT_V_CKC);

    always_comb begin
        ifc.code = '0;
        ifc.code[P_SD] = ifc.sd;
        ifc.code[P_PD] = ifc.pd;
        ifc.code[P_SR] = ifc.sr;
        // Timing damage cannot be pinned on one facility, so both go up.
        ifc.code[P_TD] = ifc.td;
        ifc.code[P_CD] = ifc.td;
        ifc.code[P_VM] = ifc.v_psw[0];
        ifc.code[P_VK] = ifc.v_psw[1];
        ifc.code[P_VP] = ifc.v_psw[2];
        ifc.code[P_VI] = ifc.v_psw[3];
        ifc.code[P_VA] = ifc.pd & (ifc.key_fail | ifc.mbit_err);
        ifc.code[P_VF] = ifc.v_regs[0];
        ifc.code[P_VG] = ifc.v_regs[1];
        ifc.code[P_VC] = ifc.v_regs[2];
        ifc.code[P_VS] = ifc.v_stor;
        ifc.code[P_VT] = ifc.v_timer[0];
        ifc.code[P_VQ] = ifc.v_timer[1];
    end

    always_comb begin
        if (ifc.key_fail) begin
            ifc.fail_addr = ifc.addr_raw & mcil_pkg::BLOCK_MASK;
        end else if (ifc.mbit_err) begin
            ifc.fail_addr = ifc.addr_raw;
        end else begin
            ifc.fail_addr = '0;
        end
    end

endmodule
`default_nettype wire

// File: hdl/mcil_top.sv
// Machine check interruption sequencer with its register port.
//
// Function
// - Status word bit 13 zero blocks every machine check interruption.
// - Recovery and external damage masks gate all but system/processing.
// - Masks gate interruption and logout only; diskette log is separate.
// - Timing damage, recovery are repressible; system, processing exigent.
// - Timing damage taken only with bit 13 and external mask set.
// - Any timing damage sets both code bits 3 and 4.
// - Clock error state or timer/comparator damage raises timing damage.
// - Set/store on damaged timer or comparator adds processing damage.
// - Recovery report taken only with bit 13 and recovery mask set.
// - Processing damage sets code bit 1, taken whenever bit 13 set.
// - Key failure gives 2K block address; multibit error the exact address.
// - System damage sets code bit 0, taken whenever bit 13 set.
// - Code is stored at locations 232 to 239 on interruption.
// - Code bits 20 to 23 mark validity of old status fields.
// - Code bit 24 marks failing address valid, stored at 248-249.
// - Code bits 27 to 29 mark saved register validity.
// - Bit 31 storage validity, bits 46 and 47 timer values.
// - Reset enables external damage and disables recovery report.
// - Normal mode exigent damage with bit 13 zero forces check stop.
`timescale 1ns/1ps
`default_nettype none
module mcil_top (
    // Clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        ce,
    // Error detection and retry events, one-cycle pulses
    input  wire logic        sys_damage_ev,
    input  wire logic        proc_damage_ev,
    input  wire logic        retry_ok_ev,
    input  wire logic        tod_error_ev,
    input  wire logic        timer_damage_ev,
    input  wire logic        timer_instr_ev,
    input  wire logic        key_fail_ev,
    input  wire logic        mbit_err_ev,
    input  wire logic [15:0] err_addr,
    // Processor state and validity of saved fields
    input  wire logic        psw_mc_mask,
    input  wire logic        normal_mode,
    input  wire logic [3:0]  valid_psw,
    input  wire logic [2:0]  valid_regs,
    input  wire logic        valid_storage,
    input  wire logic [1:0]  valid_timers,
    // Interruption sequencing handshake
    output logic             mc_int_req,
    output logic             mc_int_exigent,
    input  wire logic        mc_int_ack,
    // Logout store port
    output logic             store_valid,
    output logic [8:0]       store_addr,
    output logic [63:0]      store_data,
    output logic [3:0]       store_len,
    // Check stop and diskette logging
    output logic             check_stop,
    output logic             diskette_log,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations and code builder.

    mcil_pkg::mcil_state_t state_r;
    mcil_pkg::mcil_state_t state_nxt;

    logic                         system_damage_flag;
    logic                         instr_processing_damage_flag;
    logic                         system_recovery_flag;
    logic                         timer_damage_flag;
    logic                         cstop_ctl_r;
    logic                         rmask_r;
    logic                         emask_r;
    logic                         key_fail_r;
    logic                         mbit_err_r;
    logic [mcil_pkg::FADDR_W-1:0] addr_r;
    logic [mcil_pkg::CODE_W-1:0]  code_r;
    logic [mcil_pkg::FADDR_W-1:0] faddr_r;
    logic                         taken_exig_r;
    logic                         check_stop_r;
    logic                         store_valid_r;
    logic [8:0]                   store_addr_r;
    logic [63:0]                  store_data_r;
    logic [3:0]                   store_len_r;
    logic                         diskette_log_r;
    logic [31:0]                  rdata_r;

    logic set_sd;
    logic set_pd;
    logic set_sr;
    logic set_td;
    logic elig_sd;
    logic elig_pd;
    logic elig_sr;
    logic elig_td;
    logic elig_any;
    logic exigent_p;
    logic take;
    logic cstop_cond;
    logic busy;

    mcil_code_if code_if ();

    mcil_code_build u_build (
        .ifc (code_if)
    );

    ////////////////////////////////////////////////////////////////////////
    // Event classification and eligibility.

    always_comb begin
        set_sd = sys_damage_ev;
        set_pd = proc_damage_ev | timer_instr_ev;
        set_sr = retry_ok_ev;
        set_td = tod_error_ev | timer_damage_ev | timer_instr_ev;
    end

    always_comb begin
        // Exigent conditions ignore the two mask bits.
        exigent_p = system_damage_flag | instr_processing_damage_flag;
        elig_sd = psw_mc_mask & system_damage_flag;
        elig_pd = psw_mc_mask & instr_processing_damage_flag;
        elig_sr = psw_mc_mask & rmask_r & system_recovery_flag;
        elig_td = psw_mc_mask & emask_r & timer_damage_flag;
        elig_any = elig_sd | elig_pd | elig_sr | elig_td;
        busy = (state_r == mcil_pkg::MCIL_SCODE) |
               (state_r == mcil_pkg::MCIL_SADDR) |
               (state_r == mcil_pkg::MCIL_REQ);
        // A new exigent event while an exigent one is being logged out
        // leaves no valid status to report, so in normal mode the processor stops.
        cstop_cond = normal_mode &
                     ((exigent_p & ~psw_mc_mask) |
                      (taken_exig_r & busy & (set_sd | set_pd)));
        take = (state_r == mcil_pkg::MCIL_REQ) & mc_int_ack & elig_any;
    end

    always_comb begin
        code_if.sd       = elig_sd;
        code_if.pd       = elig_pd;
        code_if.sr       = elig_sr;
        code_if.td       = elig_td;
        code_if.v_psw    = valid_psw;
        code_if.v_regs   = valid_regs;
        code_if.v_stor   = valid_storage;
        code_if.v_timer  = valid_timers;
        code_if.key_fail = key_fail_r;
        code_if.mbit_err = mbit_err_r;
        code_if.addr_raw = addr_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pending flags; an event in the cycle of its clear wins.

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            system_damage_flag           <= 1'b0;
            instr_processing_damage_flag <= 1'b0;
            system_recovery_flag         <= 1'b0;
            timer_damage_flag            <= 1'b0;
        end else if (ce) begin
            system_damage_flag <= set_sd |
                                  (system_damage_flag & ~(take & elig_sd));
            instr_processing_damage_flag <= set_pd |
                (instr_processing_damage_flag & ~(take & elig_pd));
            system_recovery_flag <= set_sr |
                (system_recovery_flag & ~(take & elig_sr));
            timer_damage_flag <= set_td |
                                 (timer_damage_flag & ~(take & elig_td));
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            key_fail_r <= 1'b0;
            mbit_err_r <= 1'b0;
            addr_r     <= '0;
        end else if (ce) begin
            if (key_fail_ev | mbit_err_ev) begin
                key_fail_r <= key_fail_ev;
                mbit_err_r <= mbit_err_ev & ~key_fail_ev;
                addr_r     <= err_addr;
            end else if (take & elig_pd) begin
                key_fail_r <= 1'b0;
                mbit_err_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interruption and logout sequencer.

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            mcil_pkg::MCIL_IDLE: begin
                if (cstop_cond) begin
                    state_nxt = mcil_pkg::MCIL_CSTOP;
                end else if (elig_any) begin
                    state_nxt = mcil_pkg::MCIL_REQ;
                end
            end
            mcil_pkg::MCIL_REQ: begin
                if (cstop_cond) begin
                    state_nxt = mcil_pkg::MCIL_CSTOP;
                end else if (take) begin
                    state_nxt = mcil_pkg::MCIL_SCODE;
                end else if (!elig_any) begin
                    state_nxt = mcil_pkg::MCIL_IDLE;
                end
            end
            mcil_pkg::MCIL_SCODE: begin
                state_nxt = cstop_cond ? mcil_pkg::MCIL_CSTOP
                                       : mcil_pkg::MCIL_SADDR;
            end
            mcil_pkg::MCIL_SADDR: begin
                state_nxt = cstop_cond ? mcil_pkg::MCIL_CSTOP
                                       : mcil_pkg::MCIL_IDLE;
            end
            mcil_pkg::MCIL_CSTOP: begin
                // Only reset leaves check stop.
                state_nxt = mcil_pkg::MCIL_CSTOP;
            end
            default: begin
                state_nxt = mcil_pkg::MCIL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r <= mcil_pkg::MCIL_IDLE;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            code_r       <= '0;
            faddr_r      <= '0;
            taken_exig_r <= 1'b0;
        end else if (ce) begin
            if (take) begin
                code_r       <= code_if.code;
                faddr_r      <= code_if.fail_addr;
                taken_exig_r <= elig_sd | elig_pd;
            end else if (state_r == mcil_pkg::MCIL_IDLE) begin
                taken_exig_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            check_stop_r <= 1'b0;
        end else if (ce) begin
            check_stop_r <= (state_nxt == mcil_pkg::MCIL_CSTOP);
        end
    end

    // The store port carries the code in one beat and the address next.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            store_valid_r <= 1'b0;
            store_addr_r  <= '0;
            store_data_r  <= '0;
            store_len_r   <= '0;
        end else if (ce) begin
            store_valid_r <= 1'b0;
            if (state_r == mcil_pkg::MCIL_SCODE && !cstop_cond) begin
                store_valid_r <= 1'b1;
                store_addr_r  <= mcil_pkg::LOC_CODE;
                store_data_r  <= code_r;
                store_len_r   <= mcil_pkg::LEN_CODE;
            end else if (state_r == mcil_pkg::MCIL_SADDR && !cstop_cond) begin
                store_valid_r <= 1'b1;
                store_addr_r  <= mcil_pkg::LOC_FADDR;
                store_data_r  <= {{(mcil_pkg::CODE_W-mcil_pkg::FADDR_W){1'b0}},
                                  faddr_r};
                store_len_r   <= mcil_pkg::LEN_FADDR;
            end
        end
    end

    // Diskette logging sees every event but key failure and multibit error, masked or not.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            diskette_log_r <= 1'b0;
        end else if (ce) begin
            diskette_log_r <= set_sd | set_pd | set_sr | set_td;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register port.

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cstop_ctl_r <= mcil_pkg::CR14_CSTOP_RV;
            rmask_r     <= mcil_pkg::CR14_RMASK_RV;
            emask_r     <= mcil_pkg::CR14_EMASK_RV;
        end else if (ce && reg_wr && reg_addr == mcil_pkg::ADDR_CR14) begin
            cstop_ctl_r <= reg_wdata[mcil_pkg::CR14_CSTOP];
            rmask_r     <= reg_wdata[mcil_pkg::CR14_RMASK];
            emask_r     <= reg_wdata[mcil_pkg::CR14_EMASK];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_r <= '0;
        end else if (ce) begin
            rdata_r <= '0;
            if (reg_rd) begin
                case (reg_addr)
                    mcil_pkg::ADDR_CR14: begin
                        rdata_r[mcil_pkg::CR14_CSTOP] <= cstop_ctl_r;
                        rdata_r[mcil_pkg::CR14_RMASK] <= rmask_r;
                        rdata_r[mcil_pkg::CR14_EMASK] <= emask_r;
                    end
                    mcil_pkg::ADDR_STATUS: begin
                        rdata_r[mcil_pkg::ST_SD_P] <= system_damage_flag;
                        rdata_r[mcil_pkg::ST_PD_P] <=
                            instr_processing_damage_flag;
                        rdata_r[mcil_pkg::ST_SR_P] <= system_recovery_flag;
                        rdata_r[mcil_pkg::ST_TD_P] <= timer_damage_flag;
                        rdata_r[mcil_pkg::ST_CSTOP] <= check_stop_r;
                        rdata_r[mcil_pkg::ST_FSM_LO +: 3] <= state_r;
                    end
                    mcil_pkg::ADDR_CODE_HI: begin
                        rdata_r <= code_r[mcil_pkg::CODE_MSB -: 32];
                    end
                    mcil_pkg::ADDR_CODE_LO: begin
                        rdata_r <= code_r[31:0];
                    end
                    mcil_pkg::ADDR_FADDR: begin
                        rdata_r[mcil_pkg::FADDR_W-1:0] <= faddr_r;
                    end
                    default: begin
                        rdata_r <= '0;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign mc_int_req     = (state_r == mcil_pkg::MCIL_REQ) & elig_any;
    assign mc_int_exigent = mc_int_req & (elig_sd | elig_pd);
    assign store_valid    = store_valid_r;
    assign store_addr     = store_addr_r;
    assign store_data     = store_data_r;
    assign store_len      = store_len_r;
    assign check_stop     = check_stop_r;
    assign diskette_log   = diskette_log_r;
    assign reg_rdata      = rdata_r;

endmodule
`default_nettype wire

// File: tb/mcil_checker.sv
// Concurrent checks on the ports of the machine check sequencer.
`timescale 1ns/1ps
`default_nettype none
module mcil_checker (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst,
    // Events and processor state
    input wire logic       sys_damage_ev,
    input wire logic       psw_mc_mask,
    input wire logic       normal_mode,
    // Interruption handshake and logout
    input wire logic       mc_int_req,
    input wire logic       mc_int_exigent,
    input wire logic       mc_int_ack,
    input wire logic       store_valid,
    input wire logic [8:0] store_addr,
    input wire logic [3:0] store_len,
    input wire logic       check_stop,
    input wire logic       diskette_log
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_ack;
        mc_int_req && mc_int_ack;
    endsequence
    sequence s_code_beat;
        store_valid && store_addr == mcil_pkg::LOC_CODE
            && store_len == mcil_pkg::LEN_CODE;
    endsequence

    no_req_masked_a: assert property (!psw_mc_mask |-> !mc_int_req)
        else $error("machine check requested while disabled");
    exigent_is_req_a: assert property (mc_int_exigent |-> mc_int_req)
        else $error("exigent flag without a request");
    req_drops_a: assert property (s_ack |=> !mc_int_req)
        else $error("request stays up after acceptance");
    code_store_a: assert property (s_ack |->
        ##2 (s_code_beat or check_stop))
        else $error("code beat missing after acceptance");
    addr_store_a: assert property (s_code_beat |=> check_stop
        || store_valid && store_addr == mcil_pkg::LOC_FADDR
        && store_len == mcil_pkg::LEN_FADDR)
        else $error("address beat does not follow code beat");
    stop_holds_a: assert property (check_stop |=>
        check_stop && !store_valid)
        else $error("check stop left or logout stored");
    stop_entry_a: assert property (sys_damage_ev && !psw_mc_mask
        && normal_mode ##1 !psw_mc_mask |=> check_stop)
        else $error("no check stop for disabled exigent damage");
    disk_log_a: assert property (sys_damage_ev |=> diskette_log)
        else $error("diskette log missing after event");
endmodule
`default_nettype wire

// File: tb/mcil_partner.sv
// Interruption sequencer model: accepts requests and captures the logout.
`timescale 1ns/1ps
`default_nettype none
module mcil_partner (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // Acceptance delay in cycles
    input wire logic [3:0]  dly,
    // Interruption handshake
    input wire logic        mc_int_req,
    output logic            mc_int_ack,
    // Logout store port
    input wire logic        store_valid,
    input wire logic [8:0]  store_addr,
    input wire logic [63:0] store_data,
    output logic [63:0]     code,
    output logic [15:0]     faddr
);
    logic [3:0] wait_r;

    // The acceptance pulse is only raised while the request is still up.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mc_int_ack <= 1'b0;
            wait_r     <= 4'h0;
        end else begin
            mc_int_ack <= 1'b0;
            wait_r     <= 4'h0;
            if (mc_int_req && !mc_int_ack) begin
                if (wait_r >= dly) begin
                    mc_int_ack <= 1'b1;
                end else begin
                    wait_r <= wait_r + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (store_valid && store_addr == 9'h0e8) begin
            code <= store_data;
        end
        if (store_valid && store_addr == 9'h0f8) begin
            faddr <= store_data[15:0];
        end
    end
endmodule
`default_nettype wire

// File: tb/tb_machine_check_interrupt_logic.sv
// Self-checking bench for the machine check sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_machine_check_interrupt_logic;
    logic clk_sys, rst, program_status_word, norm, wr, rd, ack;
    logic [7:0] ev, addr;
    logic [15:0] ea, pfa;
    logic [31:0] wd, rdat;
    logic [63:0] sdat, pcode;
    logic [8:0] sa;
    logic [3:0] sl, dly;
    logic sv, req, exg, cst, dlog;
    int fails, comparisons, cyc;

    mcil_top DUT (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
        .sys_damage_ev(ev[0]), .proc_damage_ev(ev[1]),
        .retry_ok_ev(ev[2]), .tod_error_ev(ev[3]),
        .timer_damage_ev(ev[4]), .timer_instr_ev(ev[5]),
        .key_fail_ev(ev[6]), .mbit_err_ev(ev[7]), .err_addr(ea),
        .psw_mc_mask(program_status_word), .normal_mode(norm), .valid_psw(4'ha),
        .valid_regs(3'h5), .valid_storage(1'b1), .valid_timers(2'h2),
        .mc_int_req(req), .mc_int_exigent(exg), .mc_int_ack(ack),
        .store_valid(sv), .store_addr(sa), .store_data(sdat),
        .store_len(sl), .check_stop(cst), .diskette_log(dlog),
        .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata(rdat));
    mcil_partner PM (.clk_sys(clk_sys), .rst(rst), .dly(dly),
        .mc_int_req(req), .mc_int_ack(ack), .store_valid(sv),
        .store_addr(sa), .store_data(sdat), .code(pcode), .faddr(pfa));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic results();
        $display("compares %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wr <= 1'b1; addr <= a; wd <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    // Read data are looked at only in the cycle after the strobe.
    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        rd <= 1'b1; addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        @(negedge clk_sys);
        chk(64'(rdat), 64'(e));
    endtask

    task automatic pulse(input logic [7:0] e, input logic [15:0] a);
        @(posedge clk_sys);
        ev <= e; ea <= a;
        @(posedge clk_sys);
        ev <= 8'h00;
    endtask

    // Type t: [0] system, [1] processing, [2] recovery, [3..4] timing.
    task automatic run(input logic [7:0] e, input logic [3:0] d,
        input logic [4:0] t, input logic fa, input logic [15:0] a,
        input logic [15:0] xa);
        logic [63:0] c;
        c = 64'h0000_0515_0001_0000; // Validity bits 21 23 27 29 31 47.
        for (int i = 0; i < 5; i++) c[63-i] = t[i];
        c[39] = fa;
        dly <= d;
        pulse(e, a);
        while (!(sv && sa == 9'h0f8)) begin
            @(negedge clk_sys);
        end
        @(negedge clk_sys);
        chk(pcode, c);
        if (fa) chk(64'(pfa), 64'(xa));
        $display("interruption test done");
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            results();
        end
    end

    initial begin
        rst = 1'b1; program_status_word = 1'b0; norm = 1'b0; wr = 1'b0; rd = 1'b0;
        ev = 8'h00; addr = 8'h00; ea = 16'h0000; wd = 32'h0; dly = 4'h0;
        fails = 0; comparisons = 0; cyc = 0;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        rreg(8'h00, 32'h0000_0005);
        rreg(8'h40, 32'h0000_0000);
        pulse(8'h01, 16'h0000);
        repeat (6) @(posedge clk_sys);
        rreg(8'h04, 32'h0000_0001);
        @(posedge clk_sys) program_status_word <= 1'b1;
        run(8'h00, 4'h0, 5'h01, 1'b0, 16'h0, 16'h0);
        run(8'h42, 4'h0, 5'h02, 1'b1, 16'h1234, 16'h1000);
        run(8'h82, 4'h3, 5'h02, 1'b1, 16'hbeef, 16'hbeef);
        run(8'h08, 4'h0, 5'h18, 1'b0, 16'h0, 16'h0);
        run(8'h10, 4'h2, 5'h18, 1'b0, 16'h0, 16'h0);
        run(8'h20, 4'h0, 5'h1a, 1'b0, 16'h0, 16'h0);
        pulse(8'h04, 16'h0000);
        rreg(8'h04, 32'h0000_0004);
        wreg(8'h00, 32'h0000_0003);
        run(8'h00, 4'h1, 5'h04, 1'b0, 16'h0, 16'h0);
        pulse(8'h08, 16'h0000);
        rreg(8'h04, 32'h0000_0008);
        wreg(8'h00, 32'h0000_0007);
        run(8'h00, 4'h0, 5'h18, 1'b0, 16'h0, 16'h0);
        run(8'h05, 4'h1, 5'h05, 1'b0, 16'h0, 16'h0);
        rreg(8'h08, 32'ha000_0515);
        @(posedge clk_sys) program_status_word <= 1'b0;
        norm <= 1'b1;
        pulse(8'h01, 16'h0000);
        repeat (3) @(negedge clk_sys);
        chk(64'(cst), 64'h1);
        $display("check stop test done");
        results();
    end
endmodule

bind mcil_top mcil_checker u_chk (.*);
`default_nettype wire
